// File: logic/mdg_memctl_diag.sv
`timescale 1ns/10ps
`include "mdg_regs.svh"
// What this block does
// (R1) load register when destination selects it
// (R2) bits 1..3 form override pointer value
// (R3) bit 8 forces pointer to override value
// (R4) bit 7 forces address parity to ones
// (R5) bits 9..10 give address shift control
// (R6) bits 11..14 low mask array errors
// (R7) bit 15 low locks check bits
// (R8) bit 17 disables last-written tracking
// (R9) bit 19 low puts refresh address out
// (R10) bit 20 returns buffer data on reads
// (R11) bit 21 clears valid and pending flags
// (R12) bit 22 low holds off reads and drains only
// (R13) bit 23 makes buffer one entry deep
// (R14) bit 24 drains buffer until empty
// (R15) bit 25 loops buffer data to latch
// (R16) bit 26 low drives address on data
// (R17) bit 27 runs timer diagnostic routine
// (R18) burst stores 64 bits as two halves
// (R19) next beat toggles lsb, swaps drivers
// (R20) busy asserted within one beat
// (R21) address to pointer latch under 2.5 beats
// (R22) plus bits act high, minus bits low
module mdg_memctl_diag
  import mdg_pkg::*;
#(
  parameter int AW = 20,
  parameter int REFRESH_CYC = `MDG_REFRESH_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // microcode destination and internal data bus
  input wire logic [`MDG_DST_W-1:0] dst_field,
  input wire logic [31:0] internal_data_bus,
  // processor memory requests
  input wire logic cpu_read,
  input wire logic cpu_write,
  input wire logic [AW-1:0] cpu_addr,
  output logic memctl_busy_n,
  output logic [31:0] read_data,
  output logic read_data_valid,
  // io input burst
  input wire logic io_burst,
  input wire logic [AW-1:0] io_burst_addr,
  input wire logic [31:0] io_data_bus_first,
  input wire logic [31:0] io_data_bus_second,
  output logic io_drv_first_en,
  output logic io_drv_second_en,
  // memory arrays
  input wire logic [31:0] memory_data_lines_in,
  input wire logic [3:0] mem_err_in,
  output logic [AW-1:0] memory_address_lines,
  output logic [(AW+7)/8-1:0] mem_addr_parity,
  output logic [1:0] addr_shift_ctl,
  output logic [31:0] memory_data_lines_out,
  output logic memory_data_lines_oe_n,
  output logic [31:0] memory_data_latch_path,
  output logic mem_rd_stb,
  output logic mem_wr_stb,
  output logic mem_refresh_stb,
  output logic [3:0] err_sampled,
  output logic lock_check_bits_n,
  // write buffer state
  output logic [`MDG_WB_PTR_W-1:0] wb_ptr,
  output logic wb_empty
);
  localparam int WBN = `MDG_WB_DEPTH;
  localparam int PW = `MDG_WB_PTR_W;
  localparam int CW = `MDG_WB_CNT_W;

  logic [`MDG_DIAG_W-1:0] diag_reg;
  mdg_mt_state_type mt_state;
  logic [PW-1:0] ovr_ptr, ptr_reg, last_wr_reg, sel_ptr, ram_rd_addr;
  logic last_ok_reg, hit_reg;
  logic wb_ptr_override_select, force_addr_parity_one;
  logic disable_last_written_algo, refresh_addr_to_mem_addr;
  logic wb_bypass_to_data_bus, clear_wb_flags, timer_nop_refresh_only;
  logic wb_single_entry, wb_force_drain, wb_loop_to_mem_latch;
  logic addr_onto_mem_data, timer_diag_routine, refresh_disable;
  logic [WBN-1:0] wb_valid_reg, wb_pend_reg;
  logic [AW-1:0] wb_addr_reg [WBN];
  logic req_rd_reg, req_wr_reg, req_done;
  logic [AW-1:0] req_addr_reg, burst_addr_reg;
  logic [31:0] req_data_reg, burst_first_reg, burst_second_reg;
  logic burst_pend_reg;
  logic hit, free_ok, pair_ok, pend_ok, wb_full;
  logic [PW-1:0] hit_idx, free_idx, pend_idx;
  logic [PW-2:0] pair_idx;
  logic [CW-1:0] pend_cnt, wb_limit;
  logic ram_wr_en;
  logic [PW-1:0] ram_wr_addr;
  logic [31:0] ram_wr_data, ram_rd_data;
  logic [AW-1:0] ma_next, refresh_addr_reg, diag_addr_reg;
  logic [`MDG_REFRESH_CNT_W-1:0] refresh_cnt_reg;
  logic refresh_due_reg;

  ////////////////////////////////////////////////////////////////////////
  // diagnostic register

  always_ff @(posedge clk) begin
    if (rst) begin
      diag_reg <= `MDG_DIAG_RESET;
    end else if (dst_field == `MDG_DST_DIAG) begin
      diag_reg <= internal_data_bus; // [R1]
    end
  end

  // active-low fields are inverted once here
  assign ovr_ptr = {diag_reg[`MDG_B_PTR_MSB], diag_reg[`MDG_B_PTR_MID],
                    diag_reg[`MDG_B_PTR_LSB]}; // [R2]
  assign wb_ptr_override_select = diag_reg[`MDG_B_PTR_SEL]; // [R22]
  assign force_addr_parity_one = diag_reg[`MDG_B_FORCE_PAR]; // [R22]
  assign disable_last_written_algo = diag_reg[`MDG_B_DIS_LW];
  assign refresh_addr_to_mem_addr = ~diag_reg[`MDG_B_REF_ADDR]; // [R22]
  assign wb_bypass_to_data_bus = diag_reg[`MDG_B_BYPASS];
  assign clear_wb_flags = diag_reg[`MDG_B_CLR_WB];
  assign timer_nop_refresh_only = ~diag_reg[`MDG_B_NOP_ONLY]; // [R22]
  assign wb_single_entry = diag_reg[`MDG_B_SINGLE];
  assign wb_force_drain = diag_reg[`MDG_B_DRAIN];
  assign wb_loop_to_mem_latch = diag_reg[`MDG_B_LOOP];
  assign addr_onto_mem_data = ~diag_reg[`MDG_B_ADDR_MD]; // [R22]
  assign timer_diag_routine = diag_reg[`MDG_B_DIAG_RT];
  assign refresh_disable = diag_reg[`MDG_B_DIS_REFRESH];

  // static controls toward the arrays
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_shift_ctl <= '0;
      lock_check_bits_n <= 1'b1;
      err_sampled <= '0;
    end else begin
      addr_shift_ctl <= {diag_reg[`MDG_B_SHIFT_HI],
                         diag_reg[`MDG_B_SHIFT_LO]}; // [R5]
      lock_check_bits_n <= diag_reg[`MDG_B_LOCK_CB]; // [R7]
      for (int i = 0; i < 4; i++) begin
        err_sampled[i] <= mem_err_in[i] &
                          diag_reg[`MDG_B_ERR_ARRAY1 - i]; // [R6]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write buffer lookup

  always_comb begin
    hit = 1'b0;
    hit_idx = '0;
    free_ok = 1'b0;
    free_idx = '0;
    pend_ok = 1'b0;
    pend_idx = '0;
    pair_ok = 1'b0;
    pair_idx = '0;
    pend_cnt = '0;
    // descending so the lowest index wins
    for (int i = WBN - 1; i >= 0; i--) begin
      if (wb_valid_reg[i] && wb_addr_reg[i] == req_addr_reg) begin
        hit = 1'b1;
        hit_idx = PW'(i);
      end
      if (!wb_pend_reg[i]) begin
        free_ok = 1'b1;
        free_idx = PW'(i);
      end else begin
        pend_ok = 1'b1;
        pend_idx = PW'(i);
      end
      pend_cnt = pend_cnt + CW'(wb_pend_reg[i]);
    end
    for (int j = WBN / 2 - 1; j >= 0; j--) begin
      if (!wb_pend_reg[2*j] && !wb_pend_reg[2*j+1]) begin
        pair_ok = 1'b1;
        pair_idx = (PW-1)'(j);
      end
    end
  end

  assign wb_limit = wb_single_entry ? CW'(1) : CW'(WBN); // [R13]
  assign wb_full = pend_cnt >= wb_limit; // [R13]

  // normal pointer source, then the override
  always_comb begin
    if (req_rd_reg) begin
      sel_ptr = hit_idx;
    end else if (!disable_last_written_algo && last_ok_reg &&
                 wb_addr_reg[last_wr_reg] == req_addr_reg) begin // [R8]
      sel_ptr = last_wr_reg;
    end else begin
      sel_ptr = free_idx;
    end
    if (wb_ptr_override_select) begin
      sel_ptr = ovr_ptr; // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request capture and busy

  assign req_done = (mt_state == MT_WBWR) || (mt_state == MT_RDONE);

  always_ff @(posedge clk) begin
    if (rst) begin
      req_rd_reg <= 1'b0;
      req_wr_reg <= 1'b0;
      memctl_busy_n <= 1'b1;
    end else if (req_done) begin
      req_rd_reg <= 1'b0;
      req_wr_reg <= 1'b0;
      memctl_busy_n <= 1'b1;
    end else if (!req_rd_reg && !req_wr_reg && (cpu_read || cpu_write)) begin
      req_rd_reg <= cpu_read;
      req_wr_reg <= cpu_write & ~cpu_read;
      memctl_busy_n <= 1'b0; // [R20]
    end
  end

  // address latch; the pointer follows two beats later
  always_ff @(posedge clk) begin
    if (!req_rd_reg && !req_wr_reg && (cpu_read || cpu_write)) begin
      req_addr_reg <= cpu_addr;
      req_data_reg <= internal_data_bus;
    end
  end

  // burst request, set wins over the take
  always_ff @(posedge clk) begin
    if (rst) begin
      burst_pend_reg <= 1'b0;
    end else if (io_burst && !burst_pend_reg) begin
      burst_pend_reg <= 1'b1;
    end else if (mt_state == MT_BURST1) begin
      burst_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (io_burst && !burst_pend_reg) begin
      burst_addr_reg <= io_burst_addr;
      burst_first_reg <= io_data_bus_first;
      burst_second_reg <= io_data_bus_second;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory timer

  always_ff @(posedge clk) begin
    if (rst) begin
      mt_state <= MT_IDLE;
    end else begin
      case (mt_state)
        MT_IDLE: begin
          if (refresh_due_reg) begin
            mt_state <= MT_REFRESH;
          end else if (timer_diag_routine) begin
            mt_state <= MT_DIAG; // [R17]
          end else if (burst_pend_reg && pair_ok &&
                       (!wb_single_entry || pend_cnt == '0)) begin
            mt_state <= MT_BURST1;
          end else if ((req_wr_reg && !wb_full) ||
                       (req_rd_reg && !timer_nop_refresh_only)) begin // [R12]
            mt_state <= MT_PTR;
          end else if (!timer_nop_refresh_only && pend_ok &&
                       (wb_force_drain || wb_full)) begin // [R14]
            mt_state <= MT_DRAIN;
          end
        end
        MT_PTR: mt_state <= req_wr_reg ? MT_WBWR : MT_READ; // [R21]
        MT_READ: mt_state <= MT_RDONE;
        MT_DRAIN: mt_state <= MT_DRWR;
        MT_DIAG: begin
          if (!timer_diag_routine || refresh_due_reg) begin
            mt_state <= MT_IDLE;
          end
        end
        MT_BURST1: mt_state <= MT_BURST2;
        default: mt_state <= MT_IDLE;
      endcase
    end
  end

  // pointer: latched two beats after the address
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= '0;
      hit_reg <= 1'b0;
    end else if (mt_state == MT_PTR) begin
      ptr_reg <= sel_ptr; // [R21]
      hit_reg <= hit;
    end else if (mt_state == MT_DRAIN) begin
      ptr_reg <= pend_idx;
    end else if (mt_state == MT_IDLE) begin
      ptr_reg <= {pair_idx, 1'b0};
    end else if (mt_state == MT_BURST1) begin
      ptr_reg[0] <= ~ptr_reg[0]; // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // write buffer store

  always_comb begin
    ram_wr_en = 1'b0;
    ram_wr_addr = ptr_reg;
    ram_wr_data = req_data_reg;
    case (mt_state)
      MT_WBWR: ram_wr_en = 1'b1;
      MT_BURST1: begin
        ram_wr_en = 1'b1; // [R18]
        ram_wr_data = burst_first_reg;
      end
      MT_BURST2: begin
        ram_wr_en = 1'b1; // [R18]
        ram_wr_data = burst_second_reg;
      end
      default: ram_wr_en = 1'b0;
    endcase
  end

  assign ram_rd_addr = (mt_state == MT_DRAIN) ? pend_idx : ptr_reg;

  mdg_wb_ram #(
    .DW(32),
    .DEPTH(WBN),
    .AW(PW)
  ) u_wb_ram (
    .clk(clk),
    .wr_en(ram_wr_en),
    .wr_addr(ram_wr_addr),
    .wr_data(ram_wr_data),
    .rd_addr(ram_rd_addr),
    .rd_data(ram_rd_data)
  );

  // entry addresses hold no control state, so no reset
  always_ff @(posedge clk) begin
    if (mt_state == MT_WBWR) begin
      wb_addr_reg[ptr_reg] <= req_addr_reg;
    end else if (mt_state == MT_BURST1) begin
      wb_addr_reg[ptr_reg] <= burst_addr_reg;
    end else if (mt_state == MT_BURST2) begin
      wb_addr_reg[ptr_reg] <= burst_addr_reg | AW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_valid_reg <= '0;
      wb_pend_reg <= '0;
      last_ok_reg <= 1'b0;
      last_wr_reg <= '0;
    end else begin
      if (ram_wr_en) begin
        wb_valid_reg[ptr_reg] <= 1'b1;
        wb_pend_reg[ptr_reg] <= 1'b1;
        last_wr_reg <= ptr_reg;
        last_ok_reg <= 1'b1;
      end
      if (mt_state == MT_DRWR) begin
        wb_pend_reg[ptr_reg] <= 1'b0;
      end
      // the diagnostic clear overrides any set in the same beat
      if (clear_wb_flags) begin
        wb_valid_reg <= '0; // [R11]
        wb_pend_reg <= '0; // [R11]
        last_ok_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ptr <= '0;
      wb_empty <= 1'b1;
    end else begin
      wb_ptr <= ptr_reg;
      wb_empty <= (pend_cnt == '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // io transceiver steering

  always_ff @(posedge clk) begin
    if (rst) begin
      io_drv_first_en <= 1'b0;
      io_drv_second_en <= 1'b0;
    end else begin
      io_drv_first_en <= (mt_state == MT_IDLE) &&
                         burst_pend_reg && pair_ok && !refresh_due_reg &&
                         !timer_diag_routine &&
                         (!wb_single_entry || pend_cnt == '0);
      io_drv_second_en <= (mt_state == MT_BURST1); // [R19]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // refresh and diagnostic address counters

  always_ff @(posedge clk) begin
    if (rst) begin
      refresh_cnt_reg <= '0;
      refresh_due_reg <= 1'b0;
      refresh_addr_reg <= '0;
    end else begin
      if (refresh_cnt_reg == `MDG_REFRESH_CNT_W'(REFRESH_CYC - 1)) begin
        refresh_cnt_reg <= '0;
      end else begin
        refresh_cnt_reg <= refresh_cnt_reg + 1'b1;
      end
      // a new tick wins over the take
      if (refresh_cnt_reg == '0 && !refresh_disable) begin
        refresh_due_reg <= 1'b1;
      end else if (mt_state == MT_REFRESH) begin
        refresh_due_reg <= 1'b0;
      end
      if (mt_state == MT_REFRESH) begin
        refresh_addr_reg <= refresh_addr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      diag_addr_reg <= '0;
    end else if (mt_state == MT_DIAG) begin
      diag_addr_reg <= diag_addr_reg + 1'b1; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory address, parity and strobes

  always_comb begin
    ma_next = memory_address_lines;
    case (mt_state)
      MT_READ: ma_next = req_addr_reg;
      MT_DRWR: ma_next = wb_addr_reg[ptr_reg];
      MT_REFRESH: ma_next = refresh_addr_reg;
      MT_DIAG: ma_next = diag_addr_reg;
      default: ma_next = memory_address_lines;
    endcase
    if (refresh_addr_to_mem_addr) begin
      ma_next = refresh_addr_reg; // [R9]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      memory_address_lines <= '0;
    end else begin
      memory_address_lines <= ma_next;
    end
  end

  mdg_addr_parity #(
    .W(AW)
  ) u_addr_parity (
    .clk(clk),
    .rst(rst),
    .addr(ma_next),
    .force_one(force_addr_parity_one), // [R4]
    .parity(mem_addr_parity)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      mem_rd_stb <= 1'b0;
      mem_wr_stb <= 1'b0;
      mem_refresh_stb <= 1'b0;
    end else begin
      mem_rd_stb <= (mt_state == MT_READ) || (mt_state == MT_DIAG);
      mem_wr_stb <= (mt_state == MT_DRWR);
      mem_refresh_stb <= (mt_state == MT_REFRESH);
    end
  end

  // data lines: drain data, or the address during processor reads
  always_ff @(posedge clk) begin
    if (rst) begin
      memory_data_lines_out <= '0;
      memory_data_lines_oe_n <= 1'b1;
    end else if (mt_state == MT_DRWR) begin
      memory_data_lines_out <= ram_rd_data; // [R14]
      memory_data_lines_oe_n <= 1'b0;
    end else if (mt_state == MT_READ && addr_onto_mem_data) begin
      memory_data_lines_out <= 32'(req_addr_reg); // [R16]
      memory_data_lines_oe_n <= 1'b0;
    end else begin
      memory_data_lines_oe_n <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read return

  always_ff @(posedge clk) begin
    if (rst) begin
      read_data <= '0;
      read_data_valid <= 1'b0;
      memory_data_latch_path <= '0;
    end else begin
      read_data_valid <= (mt_state == MT_RDONE);
      if (mt_state == MT_RDONE) begin
        // a hit on a buffered entry must see the newer data
        read_data <= (wb_bypass_to_data_bus || hit_reg) ?
                     ram_rd_data : memory_data_lines_in; // [R10]
        memory_data_latch_path <= wb_loop_to_mem_latch ?
                                  ram_rd_data : memory_data_lines_in; // [R15]
      end
    end
  end
endmodule : mdg_memctl_diag

// File: logic/mdg_regs.svh
`ifndef MDG_REGS_SVH
`define MDG_REGS_SVH

// destination decode
`define MDG_DST_W 6
`define MDG_DST_DIAG 6'h2a

// diagnostic register, documented bit n sits at index 32-n
`define MDG_DIAG_W 32
`define MDG_DIAG_RESET 32'h0c3e2440
`define MDG_B_PTR_MSB 31
`define MDG_B_PTR_MID 30
`define MDG_B_PTR_LSB 29
`define MDG_B_FORCE_PAR 25
`define MDG_B_PTR_SEL 24
`define MDG_B_SHIFT_HI 23
`define MDG_B_SHIFT_LO 22
`define MDG_B_ERR_ARRAY1 21
`define MDG_B_LOCK_CB 17
`define MDG_B_DIS_REFRESH 16
`define MDG_B_DIS_LW 15
`define MDG_B_REF_ADDR 13
`define MDG_B_BYPASS 12
`define MDG_B_CLR_WB 11
`define MDG_B_NOP_ONLY 10
`define MDG_B_SINGLE 9
`define MDG_B_DRAIN 8
`define MDG_B_LOOP 7
`define MDG_B_ADDR_MD 6
`define MDG_B_DIAG_RT 5

// write buffer
`define MDG_WB_DEPTH 8
`define MDG_WB_PTR_W 3
`define MDG_WB_CNT_W 4

// timing
`define MDG_CLK_NS 4
`define MDG_BEAT_NS 4
`define MDG_PTR_LAT_MAX_NS ((5 * `MDG_BEAT_NS) / 2)
`define MDG_PTR_LAT_MAX_CYC (`MDG_PTR_LAT_MAX_NS / `MDG_CLK_NS)
`define MDG_REFRESH_NS 15600
`define MDG_REFRESH_CYC (`MDG_REFRESH_NS / `MDG_CLK_NS)
`define MDG_REFRESH_CNT_W 12

`endif

// File: logic/mdg_pkg.sv
package mdg_pkg;
  typedef enum logic [3:0] {
    MT_IDLE,
    MT_PTR,
    MT_WBWR,
    MT_READ,
    MT_RDONE,
    MT_DRAIN,
    MT_DRWR,
    MT_REFRESH,
    MT_DIAG,
    MT_BURST1,
    MT_BURST2
  } mdg_mt_state_type;
endpackage : mdg_pkg

// File: logic/mdg_wb_ram.sv
`timescale 1ns/10ps
module mdg_wb_ram #(
  parameter int DW = 32,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  // clock
  input wire logic clk,
  // write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  // read port, data one cycle later
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read, old data on a same-address collision
  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule : mdg_wb_ram

// File: logic/mdg_addr_parity.sv
`timescale 1ns/10ps
module mdg_addr_parity #(
  parameter int W = 20,
  parameter int NP = (W + 7) / 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // address about to be driven
  input wire logic [W-1:0] addr,
  input wire logic force_one,
  // one odd parity bit per address byte
  output logic [NP-1:0] parity
);
  logic [NP*8-1:0] padded;
  logic [NP-1:0] parity_next;

  assign padded = {{(NP*8-W){1'b0}}, addr};

  for (genvar i = 0; i < NP; i++) begin : g_byte
    assign parity_next[i] = force_one | ~(^padded[i*8 +: 8]);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      parity <= '1;
    end else begin
      parity <= parity_next;
    end
  end
endmodule : mdg_addr_parity

// File: tb/mdg_memctl_diag_checker.sv
`timescale 1ns/10ps
`include "mdg_regs.svh"
module mdg_memctl_diag_checker #(
  parameter int AW = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register load and cpu side
  input wire logic [`MDG_DST_W-1:0] dst_field,
  input wire logic [31:0] internal_data_bus,
  input wire logic cpu_write,
  input wire logic memctl_busy_n,
  // burst side
  input wire logic io_burst,
  input wire logic io_drv_first_en,
  input wire logic io_drv_second_en,
  // array side and buffer state
  input wire logic [3:0] mem_err_in,
  input wire logic [(AW+7)/8-1:0] mem_addr_parity,
  input wire logic [1:0] addr_shift_ctl,
  input wire logic [3:0] err_sampled,
  input wire logic lock_check_bits_n,
  input wire logic [`MDG_WB_PTR_W-1:0] wb_ptr,
  input wire logic wb_empty
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic ld;
  assign ld = dst_field == `MDG_DST_DIAG;
  ////////////////////////////////////////////////////////////////////////////
  a_shift_load: assert property (
    ld ##1 !ld |=> addr_shift_ctl == $past(internal_data_bus[23:22], 2))
    else $error("shift field not loaded");
  a_lock_load: assert property (
    ld ##1 !ld |=> lock_check_bits_n == $past(internal_data_bus[17], 2))
    else $error("lock bit not loaded");
  a_err_masked: assert property (
    ld && internal_data_bus[21:18] == 4'h0 ##1 !ld [*3] |->
      err_sampled == 4'h0)
    else $error("masked array error sampled");
  a_parity_forced: assert property (
    ld && internal_data_bus[25] ##1 !ld [*3] |-> &mem_addr_parity)
    else $error("parity not forced");
  a_busy_write: assert property (
    cpu_write && memctl_busy_n |=> !memctl_busy_n)
    else $error("busy late");
  // a full buffer drains first, so the bound is generous
  a_busy_bound: assert property (
    $fell(memctl_busy_n) |-> ##[1:40] memctl_busy_n)
    else $error("busy stuck");
  a_burst_start: assert property (
    io_burst && !$past(io_burst) && !io_drv_first_en && !io_drv_second_en
      |-> ##[2:8] io_drv_first_en)
    else $error("burst not started");
  a_burst_halves: assert property (
    io_drv_first_en |=> io_drv_second_en && !io_drv_first_en ##1
      wb_ptr[0] != $past(wb_ptr[0]))
    else $error("second half not switched");
  a_wb_cleared: assert property (
    ld && internal_data_bus[11] ##1 !ld [*3] |-> wb_empty)
    else $error("buffer not cleared");
endmodule : mdg_memctl_diag_checker

bind mdg_memctl_diag mdg_memctl_diag_checker #(.AW(AW)) u_checker (.*);

// File: tb/mdg_mem_model.sv
`timescale 1ns/10ps
module mdg_mem_model (
  // clock
  input wire logic clk,
  // controller side
  input wire logic [19:0] memory_address_lines,
  input wire logic mem_rd_stb,
  output logic [31:0] memory_data_lines_in,
  output logic [3:0] mem_err_in,
  // error levels set by the bench
  input wire logic [3:0] err_inj
);
  logic [31:0] last_reg = 32'h0;
  ////////////////////////////////////////////////////////////////////////////
  // outside a read the lines flip every cycle, so stale data never matches
  always_comb begin
    if (mem_rd_stb) begin
      memory_data_lines_in = {12'h5a3, memory_address_lines};
    end else begin
      memory_data_lines_in = ~last_reg;
    end
  end
  always_ff @(posedge clk) begin
    last_reg <= memory_data_lines_in;
  end
  assign mem_err_in = err_inj;
endmodule : mdg_mem_model

// File: tb/mdg_memctl_diag_bench.sv
`timescale 1ns/10ps
`include "mdg_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module mdg_memctl_diag_bench;
  localparam logic [31:0] DEF = `MDG_DIAG_RESET;
  logic clk, rst, cpu_read, cpu_write, io_burst, saw_md;
  logic [5:0] dst_field;
  logic [31:0] internal_data_bus, io_data_bus_first, io_data_bus_second;
  logic [19:0] cpu_addr, io_burst_addr, memory_address_lines;
  logic [31:0] read_data, memory_data_lines_in, memory_data_lines_out;
  logic [31:0] memory_data_latch_path;
  logic [3:0] mem_err_in, err_sampled, err_inj;
  logic [2:0] mem_addr_parity, wb_ptr;
  logic [1:0] addr_shift_ctl;
  logic memctl_busy_n, read_data_valid, io_drv_first_en, io_drv_second_en;
  logic memory_data_lines_oe_n, mem_rd_stb, mem_wr_stb, mem_refresh_stb;
  logic lock_check_bits_n, wb_empty;
  int n_fail = 0;
  int n_compared = 0;
  logic [52:0] wq[$];
  mdg_memctl_diag #(.AW(20), .REFRESH_CYC(64)) dut (.*);
  mdg_mem_model u_mem (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (mem_wr_stb === 1'b1) begin
      wq.push_back({memory_data_lines_oe_n, memory_address_lines,
                    memory_data_lines_out});
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic put(input logic [31:0] w);
    @(posedge clk);
    dst_field <= `MDG_DST_DIAG;
    internal_data_bus <= w;
    @(posedge clk);
    dst_field <= 6'h00;
  endtask : put
  task automatic load(input logic [31:0] w);
    put(w);
    tick(3);
  endtask : load
  task automatic req(input logic rd, input logic [19:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    cpu_read <= rd;
    cpu_write <= !rd;
    cpu_addr <= a;
    internal_data_bus <= d;
    @(posedge clk);
    cpu_read <= 1'b0;
    cpu_write <= 1'b0;
  endtask : req
  // bounded wait for read data or the end of busy
  task automatic wait_done(input logic rd);
    for (int i = 0; i < 60; i++) begin
      tick(1);
      if (memory_data_lines_oe_n === 1'b0 &&
          memory_data_lines_out[19:0] === cpu_addr) saw_md = 1'b1;
      if (rd ? read_data_valid === 1'b1 : memctl_busy_n === 1'b1) return;
    end
    n_fail++;
    $display("ERROR %0t wait ran out", $time);
    stop_test();
  endtask : wait_done
  function automatic logic has(input logic [52:0] e);
    foreach (wq[k]) if (wq[k] === e) return 1'b1;
    return 1'b0;
  endfunction : has
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fields;
    for (int v = 0; v < 4; v++) begin
      load(DEF | (32'(v) << 22));
      `CHK(addr_shift_ctl, 2'(v))
    end
    `CHK(lock_check_bits_n, 1'b1)
    `CHK(err_sampled, 4'hf)
    load((DEF & ~32'h003e_2000) | 32'h0200_0000);
    `CHK(lock_check_bits_n, 1'b0)
    `CHK(err_sampled, 4'h0)
    `CHK(mem_addr_parity, 3'h7)
    `CHK(memory_address_lines, 20'h00001)
    load(DEF & ~32'h0000_2000);
    `CHK(mem_addr_parity, 3'h6)
    load(DEF);
    $display("t_fields done");
  endtask : t_fields
  task automatic t_drain;
    @(posedge clk);
    io_burst <= 1'b1;
    io_burst_addr <= 20'h00040;
    io_data_bus_first <= 32'h1111_aaaa;
    io_data_bus_second <= 32'h2222_bbbb;
    @(posedge clk);
    io_burst <= 1'b0;
    tick(6);
    req(1'b0, 20'h00100, 32'h3333_cccc);
    wait_done(1'b0);
    wq.delete();
    load(DEF | 32'h0000_0100);
    tick(40);
    `CHK(has({1'b0, 20'h00040, 32'h1111_aaaa}), 1'b1)
    `CHK(has({1'b0, 20'h00041, 32'h2222_bbbb}), 1'b1)
    `CHK(has({1'b0, 20'h00100, 32'h3333_cccc}), 1'b1)
    `CHK(wq.size(), 3)
    `CHK(wb_empty, 1'b1)
    load(DEF);
    $display("t_drain done");
  endtask : t_drain
  task automatic t_clear;
    req(1'b0, 20'h00200, 32'hdead_beef);
    wait_done(1'b0);
    tick(1);
    `CHK(wb_empty, 1'b0)
    load(DEF | 32'h0000_0800);
    `CHK(wb_empty, 1'b1)
    load(DEF);
    req(1'b1, 20'h00200, 32'h0);
    wait_done(1'b1);
    `CHK(read_data, {12'h5a3, 20'h00200})
    load(DEF | 32'h2100_1000);
    req(1'b1, 20'h00200, 32'h0);
    wait_done(1'b1);
    `CHK(read_data, 32'h2222_bbbb)
    $display("t_clear done");
  endtask : t_clear
  // the read stays held while blocked, then must complete
  task automatic t_nop;
    int n;
    n = 0;
    load(DEF & ~32'h0000_0400);
    req(1'b1, 20'h00300, 32'h0);
    repeat (20) begin
      tick(1);
      if (mem_rd_stb === 1'b1) n++;
    end
    `CHK(n, 0)
    put(DEF);
    wait_done(1'b1);
    `CHK(read_data, {12'h5a3, 20'h00300})
    $display("t_nop done");
  endtask : t_nop
  task automatic t_addr_md;
    saw_md = 1'b0;
    load(DEF & ~32'h0000_0040);
    req(1'b1, 20'h00345, 32'h0);
    wait_done(1'b1);
    `CHK(saw_md, 1'b1)
    load(DEF);
    $display("t_addr_md done");
  endtask : t_addr_md
  task automatic t_diag;
    logic [19:0] a;
    load(DEF | 32'h0000_0020);
    a = memory_address_lines;
    tick(16);
    `CHK(mem_rd_stb, 1'b1)
    `CHK(memory_address_lines === a, 1'b0)
    load(DEF);
    tick(8);
    $display("t_diag done");
  endtask : t_diag
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    cpu_read = 1'b0;
    cpu_write = 1'b0;
    io_burst = 1'b0;
    saw_md = 1'b0;
    dst_field = 6'h00;
    internal_data_bus = 32'h0;
    io_data_bus_first = 32'h0;
    io_data_bus_second = 32'h0;
    cpu_addr = 20'h0;
    io_burst_addr = 20'h0;
    err_inj = 4'hf;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_fields();
    t_drain();
    t_clear();
    t_nop();
    t_addr_md();
    t_diag();
    stop_test();
  end
endmodule : mdg_memctl_diag_bench
